// File: rtl/cise_pkg.sv
// constants and carriers for the instruction subset execution block
// assumes a single 20 MHz instruction clock and an external decoder
// Function
// - return pops the stack and loads pc from the popped top value
// - return takes two instruction cycles
// - sleep clears watchdog count to 00h and its prescaler
// - sleep sets the timeout flag to one
// - sleep clears the powerdown flag to zero
// - after sleep the core halts; no further instruction cycles
// - literal minus acc goes to acc, updates carry, digit carry, zero
// - file minus acc, updates carry, digit carry, zero
// - destination select 0 writes acc, 1 writes the file register
// - xor literal into acc, updates only zero flag
// - xor file to selected destination, updates only zero flag
// - nibble swap exchanges nibbles, leaves all flags unchanged
package cise_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W   = 13;
    localparam int NIB_W  = 4;
    localparam logic [DATA_W-1:0] ACC_RST      = 8'h00;
    localparam logic [DATA_W-1:0] WDOG_CLR_VAL = 8'h00;
    localparam logic              DEST_ACC     = 1'b0;

    typedef enum logic [2:0] {
        CISE_OP_NONE, CISE_OP_RETURN, CISE_OP_SLEEP, CISE_OP_LIT_MINUS_ACC,
        CISE_OP_FILE_MINUS_ACC, CISE_OP_XOR_LIT, CISE_OP_XOR_FILE, CISE_OP_NIBBLE_SWAP
    } cise_op_e;

    typedef struct packed {
        cise_op_e          op;
        logic [DATA_W-1:0] literal;
        logic [ADDR_W-1:0] file_addr;
        logic              dest_sel;
        logic [DATA_W-1:0] file_data;
    } cise_instr_s;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cise_fwrite_s;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        logic              carry;
        logic              digit_carry;
    } cise_alu_s;
endpackage

// File: rtl/cise_alu.sv
// combinational arithmetic for the subtract, xor and swap operations
// assumes operands already fetched by the caller
`timescale 1ns/1ps
module cise_alu
    import cise_pkg::*;
(
    input  wire cise_pkg::cise_op_e       op,
    input  wire logic [cise_pkg::DATA_W-1:0] src,
    input  wire logic [cise_pkg::DATA_W-1:0] acc,
    output cise_pkg::cise_alu_s           res
);
    logic [DATA_W:0] diff;
    logic [NIB_W:0]  low_diff;

    always_comb begin
        // carry out of src + ~acc + 1 is the no-borrow indication
        diff     = {1'b0, src} + {1'b0, ~acc} + {{DATA_W{1'b0}}, 1'b1};
        low_diff = {1'b0, src[NIB_W-1:0]} + {1'b0, ~acc[NIB_W-1:0]} + {{NIB_W{1'b0}}, 1'b1};
        res.carry       = diff[DATA_W];
        res.digit_carry = low_diff[NIB_W];
        case (op)
            CISE_OP_LIT_MINUS_ACC,
            CISE_OP_FILE_MINUS_ACC: res.result = diff[DATA_W-1:0];
            CISE_OP_XOR_LIT,
            CISE_OP_XOR_FILE:       res.result = src ^ acc;
            CISE_OP_NIBBLE_SWAP:    res.result = {src[NIB_W-1:0], src[DATA_W-1:NIB_W]};
            default:                res.result = src;
        endcase
    end
endmodule

// File: rtl/cise_core.sv
// execution of return, sleep, subtract, xor and nibble swap
// assumes a decoder presents one instruction with instr_valid per free cycle
`timescale 1ns/1ps
module cise_core
    import cise_pkg::*;
(
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire logic                           instr_valid,
    input  cise_pkg::cise_instr_s               instr,
    input  wire logic [cise_pkg::PC_W-1:0]      stack_top_value,
    output logic                                instr_ready,
    output logic                                stack_pop,
    output logic                                pc_load,
    output logic [cise_pkg::PC_W-1:0]           pc_value,
    output logic [cise_pkg::DATA_W-1:0]         acc,
    output cise_pkg::cise_fwrite_s              fwrite,
    output logic                                carry_flag,
    output logic                                digit_carry_flag,
    output logic                                zero_flag,
    output logic                                timeout_flag,
    output logic                                powerdown_flag,
    output logic                                watchdog_clear,
    output logic [cise_pkg::DATA_W-1:0]         watchdog_count,
    output logic                                sleeping
);
    // ***********************************************************
    // state
    // ***********************************************************
    typedef enum logic [1:0] {CISE_ST_RUN, CISE_ST_RET2, CISE_ST_SLEEP} cise_state_e;

    typedef struct packed {
        cise_state_e         st;
        logic [DATA_W-1:0]   acc;
        logic                c, dc, z, to, pd;
        logic                pop, pcl, wclr;
        logic [PC_W-1:0]     pc;
        cise_fwrite_s        fw;
    } cise_core_s;

    cise_core_s cur, next_cur;
    cise_alu_s  alu;
    logic [DATA_W-1:0] src;
    logic              go;

    assign src = (instr.op == CISE_OP_LIT_MINUS_ACC || instr.op == CISE_OP_XOR_LIT) ?
                 instr.literal : instr.file_data;
    assign instr_ready = (cur.st == CISE_ST_RUN);
    assign go = instr_valid && instr_ready;

    cise_alu u_alu (
        .op  (instr.op),
        .src (src),
        .acc (cur.acc),
        .res (alu)
    );

    // ***********************************************************
    // next state
    // ***********************************************************
    always_comb begin
        next_cur      = cur;
        next_cur.pop  = 1'b0;
        next_cur.pcl  = 1'b0;
        next_cur.wclr = 1'b0;
        next_cur.fw.we = 1'b0;
        case (cur.st)
            CISE_ST_RUN: begin
                if (go) begin
                    case (instr.op)
                        CISE_OP_RETURN: begin
                            next_cur.pop = 1'b1;
                            next_cur.pcl = 1'b1;
                            next_cur.pc  = stack_top_value;
                            next_cur.st  = CISE_ST_RET2;
                        end
                        CISE_OP_SLEEP: begin
                            next_cur.wclr = 1'b1;
                            next_cur.to   = 1'b1;
                            next_cur.pd   = 1'b0;
                            next_cur.st   = CISE_ST_SLEEP;
                        end
                        CISE_OP_LIT_MINUS_ACC, CISE_OP_XOR_LIT: begin
                            next_cur.acc = alu.result;
                        end
                        CISE_OP_FILE_MINUS_ACC, CISE_OP_XOR_FILE, CISE_OP_NIBBLE_SWAP: begin
                            if (instr.dest_sel == DEST_ACC) begin
                                next_cur.acc = alu.result;
                            end else begin
                                next_cur.fw.we   = 1'b1;
                                next_cur.fw.addr = instr.file_addr;
                                next_cur.fw.data = alu.result;
                            end
                        end
                        default: ;
                    endcase
                    if (instr.op == CISE_OP_LIT_MINUS_ACC || instr.op == CISE_OP_FILE_MINUS_ACC) begin
                        next_cur.c  = alu.carry;
                        next_cur.dc = alu.digit_carry;
                    end
                    if (instr.op == CISE_OP_LIT_MINUS_ACC || instr.op == CISE_OP_FILE_MINUS_ACC ||
                        instr.op == CISE_OP_XOR_LIT || instr.op == CISE_OP_XOR_FILE) begin
                        next_cur.z = (alu.result == ACC_RST);
                    end
                end
            end
            CISE_ST_RET2:  next_cur.st = CISE_ST_RUN;
            // oscillator is stopped; only reset leaves sleep here
            CISE_ST_SLEEP: next_cur.st = CISE_ST_SLEEP;
            default:       next_cur.st = CISE_ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '{st: CISE_ST_RUN, acc: ACC_RST, c: 1'b0, dc: 1'b0, z: 1'b0,
                     to: 1'b1, pd: 1'b1, pop: 1'b0, pcl: 1'b0, wclr: 1'b0,
                     pc: '0, fw: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign stack_pop        = cur.pop;
    assign pc_load          = cur.pcl;
    assign pc_value         = cur.pc;
    assign acc              = cur.acc;
    assign fwrite           = cur.fw;
    assign carry_flag       = cur.c;
    assign digit_carry_flag = cur.dc;
    assign zero_flag        = cur.z;
    assign timeout_flag     = cur.to;
    assign powerdown_flag   = cur.pd;
    assign watchdog_clear   = cur.wclr;
    assign watchdog_count   = WDOG_CLR_VAL;  // value the watchdog takes on clear
    assign sleeping         = (cur.st == CISE_ST_SLEEP);

    // ***********************************************************
    // checks
    // ***********************************************************
    chk_return_pc_load: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_RETURN |=> pc_load && stack_pop && pc_value == $past(stack_top_value))
        else $error("return did not load pc from stack top");
    chk_return_two_cycles: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_RETURN |=> !instr_ready ##1 instr_ready)
        else $error("return not two cycles");
    chk_sleep_wdog_clear: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_SLEEP |=> watchdog_clear)
        else $error("sleep did not clear watchdog");
    chk_sleep_timeout_set: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_SLEEP |=> timeout_flag)
        else $error("sleep did not set timeout flag");
    chk_sleep_pd_clear: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_SLEEP |=> !powerdown_flag)
        else $error("sleep did not clear powerdown flag");
    chk_sleep_halts: assert property (@(posedge sys_clk) disable iff (rst)
        sleeping |=> sleeping && !instr_ready && $stable(acc))
        else $error("activity while sleeping");
    chk_sub_lit_result: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_LIT_MINUS_ACC |=>
            acc == $past(instr.literal) - $past(acc) && zero_flag == (acc == 8'h00))
        else $error("literal minus acc wrong");
    chk_sub_file_carry: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_FILE_MINUS_ACC |=> carry_flag == ($past(instr.file_data) >= $past(acc)))
        else $error("subtract carry wrong");
    chk_dest_file_write: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_XOR_FILE && instr.dest_sel |=> fwrite.we && $stable(acc))
        else $error("destination select one did not write file");
    chk_xor_flags_kept: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_XOR_FILE |=> $stable(carry_flag) && $stable(digit_carry_flag))
        else $error("xor changed carry flags");
    chk_swap_flags_kept: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_NIBBLE_SWAP && !instr.dest_sel |=>
            $stable(zero_flag) && $stable(carry_flag) && acc == {$past(instr.file_data[3:0]), $past(instr.file_data[7:4])})
        else $error("nibble swap wrong");

    // ***********************************************************
    // checks on destinations and the flags each operation may touch
    // ***********************************************************
    // a wrong destination corrupts data silently, so every path is pinned
    chk_sub_file_dest: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_FILE_MINUS_ACC && instr.dest_sel |=>
            fwrite.we && fwrite.addr == $past(instr.file_addr) && $stable(acc) &&
            fwrite.data == $past(instr.file_data) - $past(acc))
        else $error("file minus acc not written back");
    chk_sub_file_acc: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_FILE_MINUS_ACC && instr.dest_sel == DEST_ACC |=>
            acc == $past(instr.file_data) - $past(acc) && zero_flag == (acc == ACC_RST))
        else $error("file minus acc into acc wrong");
    chk_sub_lit_carry: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_LIT_MINUS_ACC |=> carry_flag == ($past(instr.literal) >= $past(acc)))
        else $error("literal subtract carry wrong");
    chk_sub_digit_carry: assert property (@(posedge sys_clk) disable iff (rst)
        go && (instr.op == CISE_OP_LIT_MINUS_ACC || instr.op == CISE_OP_FILE_MINUS_ACC) |=>
            digit_carry_flag == ($past(src[NIB_W-1:0]) >= $past(acc[NIB_W-1:0])))
        else $error("subtract digit carry wrong");
    chk_xor_lit_result: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_XOR_LIT |=> acc == ($past(instr.literal) ^ $past(acc)) &&
            zero_flag == (acc == ACC_RST) && $stable(carry_flag) && $stable(digit_carry_flag))
        else $error("xor literal wrong");
    chk_xor_file_acc: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_XOR_FILE && instr.dest_sel == DEST_ACC |=>
            acc == ($past(instr.file_data) ^ $past(acc)) && zero_flag == (acc == ACC_RST))
        else $error("xor file into acc wrong");
    chk_dest_acc_kept: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.dest_sel == DEST_ACC && (instr.op == CISE_OP_FILE_MINUS_ACC ||
            instr.op == CISE_OP_XOR_FILE || instr.op == CISE_OP_NIBBLE_SWAP) |=> !fwrite.we)
        else $error("destination select zero wrote the file");
    chk_literal_no_write: assert property (@(posedge sys_clk) disable iff (rst)
        go && (instr.op == CISE_OP_LIT_MINUS_ACC || instr.op == CISE_OP_XOR_LIT) |=> !fwrite.we)
        else $error("literal operation wrote the file");
    chk_swap_file_write: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_NIBBLE_SWAP && instr.dest_sel |=>
            fwrite.we && fwrite.data == {$past(instr.file_data[NIB_W-1:0]), $past(instr.file_data[DATA_W-1:NIB_W])} &&
            $stable(zero_flag) && $stable(carry_flag) && $stable(digit_carry_flag) && $stable(acc))
        else $error("nibble swap to file wrong");
    // a second pop would lose a return address
    chk_return_single_pop: assert property (@(posedge sys_clk) disable iff (rst)
        go && instr.op == CISE_OP_RETURN |=> ##1 !stack_pop && !pc_load)
        else $error("return popped more than once");
    chk_sleep_no_effects: assert property (@(posedge sys_clk) disable iff (rst)
        sleeping |=> !fwrite.we && !stack_pop && !pc_load && !watchdog_clear)
        else $error("side effect while sleeping");
endmodule

// File: bench/tb_cpu_instr_subset_exec.sv
// self-checking bench for the instruction subset execution core
// assumes cise_pkg and cise_core compiled first; the bench drives every core input itself
`timescale 1ns/1ps
module tb_cpu_instr_subset_exec;
    import cise_pkg::*;
    // ************************************************************
    // signals and the table of ordinary cases
    // ************************************************************
    typedef struct packed {
        cise_op_e          op;
        logic [7:0]        lit;
        logic [6:0]        addr;
        logic              dest;
        logic [7:0]        fd;
        logic [7:0]        acc;
        logic              c;
        logic              dc;
        logic              z;
        logic              we;
        logic [7:0]        wd;
    } cise_row_s;
    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic              instr_valid = 1'b0;
    cise_instr_s       instr = '0;
    logic [PC_W-1:0]   stack_top_value = '0;
    logic              instr_ready, stack_pop, pc_load, carry_flag, digit_carry_flag, zero_flag;
    logic              timeout_flag, powerdown_flag, watchdog_clear, sleeping;
    logic [PC_W-1:0]   pc_value;
    logic [DATA_W-1:0] acc, watchdog_count;
    cise_fwrite_s      fwrite;
    cise_row_s         rows[12];
    cise_row_s         r;
    int                n_fail = 0;
    int                n_tests = 0;

    cise_core i_cise_core (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .stack_top_value(stack_top_value), .instr_ready(instr_ready), .stack_pop(stack_pop),
        .pc_load(pc_load), .pc_value(pc_value), .acc(acc), .fwrite(fwrite), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag), .watchdog_clear(watchdog_clear),
        .watchdog_count(watchdog_count), .sleeping(sleeping));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one transfer: present, taken at the next edge, results sampled mid-cycle after it
    task automatic issue(input cise_op_e op, input logic [7:0] lit, input logic [6:0] a,
                         input logic d, input logic [7:0] fd);
        @(posedge sys_clk);
        instr <= '{op, lit, a, d, fd};
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic chk_reset();
        chk({acc, carry_flag, digit_carry_flag, zero_flag}, 16'h0000, "reset acc flags");
        chk({timeout_flag, powerdown_flag, instr_ready, sleeping}, 16'h000E, "reset status");
    endtask
    task automatic close_out();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        // acc chains from row to row, so the order of rows matters
        rows = '{
            '{CISE_OP_LIT_MINUS_ACC,  8'h05, 7'h00, 1'b0, 8'h00, 8'h05, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00},
            '{CISE_OP_LIT_MINUS_ACC,  8'h03, 7'h00, 1'b0, 8'h00, 8'hFE, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00},
            '{CISE_OP_XOR_LIT,        8'hFE, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00},
            '{CISE_OP_LIT_MINUS_ACC,  8'h00, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00},
            '{CISE_OP_XOR_LIT,        8'h3C, 7'h00, 1'b0, 8'h00, 8'h3C, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00},
            '{CISE_OP_FILE_MINUS_ACC, 8'h00, 7'h11, 1'b0, 8'h40, 8'h04, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00},
            '{CISE_OP_FILE_MINUS_ACC, 8'h00, 7'h7F, 1'b1, 8'h04, 8'h04, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00},
            '{CISE_OP_XOR_FILE,       8'h00, 7'h00, 1'b1, 8'h0F, 8'h04, 1'b1, 1'b1, 1'b0, 1'b1, 8'h0B},
            '{CISE_OP_XOR_FILE,       8'h00, 7'h22, 1'b0, 8'h04, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00},
            '{CISE_OP_NIBBLE_SWAP,    8'h00, 7'h33, 1'b0, 8'hA5, 8'h5A, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00},
            '{CISE_OP_NIBBLE_SWAP,    8'h00, 7'h55, 1'b1, 8'h3C, 8'h5A, 1'b1, 1'b1, 1'b1, 1'b1, 8'hC3},
            '{CISE_OP_FILE_MINUS_ACC, 8'h00, 7'h44, 1'b0, 8'h10, 8'hB6, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00}};
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk_reset();
        @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            issue(r.op, r.lit, r.addr, r.dest, r.fd);
            chk(acc, r.acc, "acc");
            chk({carry_flag, digit_carry_flag}, {r.c, r.dc}, "carry pair");
            chk(zero_flag, r.z, "zero");
            chk(fwrite.we, r.we, "file write strobe");
            if (r.we) chk({fwrite.addr, fwrite.data}, {r.addr, r.wd}, "file write");
        end
        // ************************************************************
        // awkward cases: return, sleep, refusal while asleep, reset again
        // ************************************************************
        @(posedge sys_clk);
        stack_top_value <= 13'h1A5C;
        issue(CISE_OP_RETURN, 8'h00, 7'h00, 1'b0, 8'h00);
        chk({stack_pop, pc_load, pc_value}, {2'b11, 13'h1A5C}, "return pop");
        chk(instr_ready, 1'b0, "ready after return");
        @(negedge sys_clk);
        chk({instr_ready, stack_pop, pc_load}, 16'h0004, "second return cycle");
        chk(acc, 8'hB6, "acc kept by return");
        issue(CISE_OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00);
        chk({watchdog_clear, watchdog_count}, 16'h0100, "watchdog cleared");
        chk(timeout_flag, 1'b1, "timeout set");
        chk(powerdown_flag, 1'b0, "powerdown cleared");
        chk({sleeping, instr_ready}, 16'h0002, "asleep");
        issue(CISE_OP_XOR_LIT, 8'hFF, 7'h00, 1'b0, 8'h00);
        chk({acc, watchdog_clear, sleeping}, {8'hB6, 2'b01}, "nothing runs asleep");
        @(posedge sys_clk);
        rst <= 1'b1;
        @(negedge sys_clk);
        chk_reset();
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        issue(CISE_OP_LIT_MINUS_ACC, 8'hFF, 7'h00, 1'b0, 8'h00);
        chk({acc, carry_flag, digit_carry_flag, zero_flag}, {8'hFF, 3'b110}, "after wake");
        close_out();
    end

    initial begin
        // about 52 cycles of work; a generous margin before calling it a hang
        repeat (2000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end
endmodule
